//--- rtl/qhp_pkg.sv
// package for the quad uart host port status block
// shared by the device top and the verification side
package qhp_pkg;
    // =========================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_HOST_CMD = 8'h00;
    localparam logic [7:0] ADDR_HOST_RDATA = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_CHAN_STAT = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam int NUM_CHAN = 4;
    localparam int REG_ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int CNT_W = 7;
    // host_cmd fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_SEL_LSB = 12;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_BCAST_BIT = 17;
    // cfg fields
    localparam int CFG_STYLE_BIT = 0;
    localparam int CFG_IRQMODE_BIT = 1;
    localparam int CFG_RESET_BIT = 2;
    // per channel register offsets and bits
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_FCR = 3'h2;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_BLOCK_BIT = 3;
    localparam int FCR_TRIG_LSB = 6;
    localparam int MCR_IRQEN_BIT = 3;
    localparam int LSR_THRE_BIT = 5;
    localparam int LSR_TEMT_BIT = 6;
    localparam logic [7:0] FCR_RESET = 8'h00;
    localparam logic [7:0] MCR_RESET = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int RX_TIMEOUT_CYC = 64;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- rtl/qhp_top.sv
// quad uart host port: channel select decode, per channel fifo status and ready/irq outputs
// assumes an axi4-lite master on aclk; serial side is modelled by rx push and tx pop strobes
`timescale 1ns/1ps
// Contract
// - eight data bits, three register address lines
// - bus access needs no baud clock
// - shared data bus, only selected responds
// - reset over 40 ns restores defaults
// - per channel low selects pick channel
// - all selects low writes all channels
// - single select plus two address bits
// - address bits ignored in separate style
// - fifo on: tx irq low above trigger
// - fifo off: rx irq high with byte
// - fifo on: rx irq high above trigger
// - fifo control bit three selects block
// - rx ready low when data held
// - block rx ready: trigger/timeout falls, empty rises
// - tx ready low only when empty
// - block tx ready low unless full
// - line status five/six: room, empty
// - one oscillator feeds every baud generator
// - irq mode pin and modem bit gate irq
module qhp_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_in,
    output logic osc_out,
    input wire logic [3:0] rx_push,
    input wire logic [3:0] tx_pop,
    output logic [3:0] irq_out,
    output logic [3:0] rx_ready_n,
    output logic [3:0] tx_ready_n
);
    import qhp_pkg::*;

    // =========================================
    // axi4-lite slave
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] cfg_reg, cfg_next;
    logic [31:0] cmd_reg, cmd_next;
    logic [7:0] hrdata_reg, hrdata_next;
    logic [2:0] rst_cnt_reg, rst_cnt_next;
    logic do_wr, do_rd, host_go;

    // per channel state
    logic [7:0] fcr_reg [NUM_CHAN];
    logic [7:0] fcr_next [NUM_CHAN];
    logic [7:0] mcr_reg [NUM_CHAN];
    logic [7:0] mcr_next [NUM_CHAN];
    logic [CNT_W-1:0] rxc_reg [NUM_CHAN];
    logic [CNT_W-1:0] rxc_next [NUM_CHAN];
    logic [CNT_W-1:0] txc_reg [NUM_CHAN];
    logic [CNT_W-1:0] txc_next [NUM_CHAN];
    logic [6:0] tmo_reg [NUM_CHAN];
    logic [6:0] tmo_next [NUM_CHAN];
    logic [3:0] rx_ready_n_reg, rx_ready_n_next;
    logic [3:0] sel;
    logic host_wr;
    logic [2:0] host_addr;
    logic [7:0] host_data;
    logic chan_rst;

    // =========================================
    // helper functions
    function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
        case (code)
            2'd0: trig_level = 7'd1;
            2'd1: trig_level = 7'd16;
            2'd2: trig_level = 7'd32;
            default: trig_level = 7'd56;
        endcase
    endfunction

    // capacity of one direction: a single holding register while the fifo is off
    function automatic logic [CNT_W-1:0] cap_of(input logic fen);
        if (fen) begin
            cap_of = 7'(FIFO_DEPTH);
        end else begin
            cap_of = 7'd1;
        end
    endfunction

    function automatic logic [7:0] lsr_of(input int c);
        logic [7:0] v;
        v = 8'h00;
        v[0] = (rxc_reg[c] != '0);
        v[LSR_THRE_BIT] = (txc_reg[c] < cap_of(fcr_reg[c][FCR_EN_BIT]));
        v[LSR_TEMT_BIT] = (txc_reg[c] == '0);
        lsr_of = v;
    endfunction

    assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign do_rd = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        cfg_next = cfg_reg;
        cmd_next = cmd_reg;
        host_go = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
        end
        if (do_wr) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            // byte strobes ignored: host_cmd always takes the whole 32-bit word, cfg its low three bits
            case (awaddr_reg)
                ADDR_HOST_CMD: begin
                    cmd_next = wdata_reg;
                    host_go = 1'b1;
                end
                ADDR_CFG: cfg_next = wdata_reg[2:0];
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (do_rd) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_HOST_CMD: rdata_next = cmd_reg;
                ADDR_HOST_RDATA: rdata_next = {24'h000000, hrdata_reg};
                ADDR_CFG: rdata_next = {29'h0, cfg_reg};
                ADDR_CHAN_STAT: rdata_next = {20'h0, irq_out, rx_ready_n, tx_ready_n};
                ADDR_STATUS: rdata_next = {1'b0, rxc_reg[3], 1'b0, rxc_reg[2], 1'b0, rxc_reg[1], 1'b0, rxc_reg[0]};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // =========================================
    // channel decode
    // decode the word being written, so the access lands on the same edge as the bus write
    always_comb begin
        host_wr = cmd_next[CMD_WRITE_BIT];
        host_addr = cmd_next[CMD_ADDR_LSB +: REG_ADDR_W];
        host_data = cmd_next[CMD_DATA_LSB +: DATA_W];
        sel = 4'b0000;
        if (cfg_reg[CFG_STYLE_BIT]) begin
            sel = ~cmd_next[CMD_SEL_LSB +: 4];
            if (!host_wr && sel == 4'b1111) begin
                sel = 4'b0000;
            end
        end else if (!cmd_next[CMD_SEL_LSB]) begin
            sel[cmd_next[CMD_SEL_LSB+2 +: 2]] = 1'b1;
        end
    end

    // software reset held one cycle beyond 40 ns
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (cfg_reg[CFG_RESET_BIT]) begin
            if (rst_cnt_reg < 3'(RESET_MIN_CYC)) begin
                rst_cnt_next = rst_cnt_reg + 3'd1;
            end
        end else begin
            rst_cnt_next = 3'd0;
        end
    end
    assign chan_rst = (rst_cnt_reg >= 3'(RESET_MIN_CYC));

    // =========================================
    // per channel registers and fifo counts
    always_comb begin
        hrdata_next = hrdata_reg;
        rx_ready_n_next = rx_ready_n_reg;
        for (int c = 0; c < NUM_CHAN; c++) begin
            fcr_next[c] = fcr_reg[c];
            mcr_next[c] = mcr_reg[c];
            rxc_next[c] = rxc_reg[c];
            txc_next[c] = txc_reg[c];
            tmo_next[c] = tmo_reg[c];
            // host access on bus clock, baud clock not needed
            // write lands in each selected channel
            if (host_go && sel[c] && host_wr) begin
                case (host_addr)
                    OFS_DATA: begin
                        if (txc_reg[c] < cap_of(fcr_reg[c][FCR_EN_BIT])) begin
                            txc_next[c] = txc_reg[c] + 7'd1;
                        end
                    end
                    OFS_FCR: fcr_next[c] = host_data;
                    OFS_MCR: mcr_next[c] = host_data;
                    default: ;
                endcase
            end
            if (host_go && sel[c] && !host_wr) begin
                case (host_addr)
                    OFS_DATA: begin
                        hrdata_next = 8'h00;
                        if (rxc_reg[c] != '0) begin
                            rxc_next[c] = rxc_reg[c] - 7'd1;
                        end
                    end
                    OFS_FCR: hrdata_next = fcr_reg[c];
                    OFS_MCR: hrdata_next = mcr_reg[c];
                    OFS_LSR: hrdata_next = lsr_of(c);
                    default: hrdata_next = 8'h00;
                endcase
            end
            // a pop on an empty transmitter is ignored
            if (tx_pop[c] && txc_next[c] != '0) begin
                txc_next[c] = txc_next[c] - 7'd1;
            end
            // a byte that finds the receiver full is lost, as an overrun would be
            if (rx_push[c] && rxc_next[c] < cap_of(fcr_reg[c][FCR_EN_BIT])) begin
                rxc_next[c] = rxc_next[c] + 7'd1;
            end
            // receive timeout: data held and no activity
            if (rx_push[c] || rxc_reg[c] == '0 || (host_go && sel[c])) begin
                tmo_next[c] = 7'd0;
            end else if (tmo_reg[c] < 7'(RX_TIMEOUT_CYC)) begin
                tmo_next[c] = tmo_reg[c] + 7'd1;
            end
            // falls at trigger or timeout, rises on empty
            if (rxc_next[c] == '0) begin
                rx_ready_n_next[c] = 1'b1;
            end else if (rxc_reg[c] >= trig_level(fcr_reg[c][FCR_TRIG_LSB +: 2])
                         || tmo_reg[c] == 7'(RX_TIMEOUT_CYC)) begin
                rx_ready_n_next[c] = 1'b0;
            end
            if (!fcr_next[c][FCR_EN_BIT] && fcr_reg[c][FCR_EN_BIT]) begin
                rxc_next[c] = '0;
                txc_next[c] = '0;
            end
        end
    end

    // =========================================
    // output pins
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            logic fen, blk, tirq, rirq;
            fen = fcr_reg[c][FCR_EN_BIT];
            // block mode only with fifo on
            blk = fen && fcr_reg[c][FCR_BLOCK_BIT];
            tirq = fen ? (txc_reg[c] <= trig_level(fcr_reg[c][FCR_TRIG_LSB +: 2])) : (txc_reg[c] == '0);
            rirq = fen ? (rxc_reg[c] >= trig_level(fcr_reg[c][FCR_TRIG_LSB +: 2])) : (rxc_reg[c] != '0);
            // mode input 1 continuous, else modem bit 3 gates
            irq_out[c] = (tirq || rirq) && (cfg_reg[CFG_IRQMODE_BIT] || mcr_reg[c][MCR_IRQEN_BIT]);
            rx_ready_n[c] = blk ? rx_ready_n_reg[c] : (rxc_reg[c] == '0);
            tx_ready_n[c] = blk ? (txc_reg[c] == 7'(FIFO_DEPTH)) : (txc_reg[c] != '0);
        end
    end

    // one oscillator shared; bus logic never uses it
    assign osc_out = ~osc_in;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
            cfg_reg <= 3'h1;
            cmd_reg <= 32'h0000f000;
            rst_cnt_reg <= 3'd0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
            cmd_reg <= cmd_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || chan_rst) begin
            hrdata_reg <= 8'h00;
            rx_ready_n_reg <= 4'hf;
            for (int c = 0; c < NUM_CHAN; c++) begin
                fcr_reg[c] <= FCR_RESET;
                mcr_reg[c] <= MCR_RESET;
                rxc_reg[c] <= '0;
                txc_reg[c] <= '0;
                tmo_reg[c] <= '0;
            end
        end else begin
            hrdata_reg <= hrdata_next;
            rx_ready_n_reg <= rx_ready_n_next;
            for (int c = 0; c < NUM_CHAN; c++) begin
                fcr_reg[c] <= fcr_next[c];
                mcr_reg[c] <= mcr_next[c];
                rxc_reg[c] <= rxc_next[c];
                txc_reg[c] <= txc_next[c];
                tmo_reg[c] <= tmo_next[c];
            end
        end
    end
endmodule

//--- test/qhp_assertions.sv
// checker for the quad uart host port status block
// sees only the top ports; bound into qhp_top below
`timescale 1ns/1ps
module qhp_chk
    import qhp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_in,
    input wire logic osc_out,
    input wire logic [3:0] tx_pop,
    input wire logic [3:0] irq_out,
    input wire logic [3:0] rx_ready_n,
    input wire logic [3:0] tx_ready_n
);
    // ====================
    // bus and status properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_out: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && irq_out == 4'h0 && rx_ready_n == 4'hf && tx_ready_n == 4'h0)
        else $error("outputs not at defaults after reset");
    a_osc_inv: assert property (osc_out == !osc_in)
        else $error("oscillator output not inverse of input");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_unmapped_err: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_tx_ready_n_cause: assert property (
        tx_pop == 4'h0 && s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid |=> $stable(tx_ready_n))
        else $error("transmit ready moved without cause");
endmodule
bind qhp_top qhp_chk i_chk (.*);

//--- test/qhp_serial_model.sv
// serial side model: received byte and transmitter pop strobes, free oscillator
// assumes calls come from a process that just passed a rising aclk edge
`timescale 1ns/1ps
module qhp_serial_model (
    input wire logic aclk,
    output logic osc_in,
    output logic [3:0] rx_push,
    output logic [3:0] tx_pop
);
    // ====================
    // strobes
    initial begin
        osc_in = 1'b0;
        rx_push = 4'h0;
        tx_pop = 4'h0;
    end
    // free running oscillator
    // unrelated to aclk so bus logic cannot lean on it
    always #27.1 osc_in = ~osc_in;
    task automatic pulse(input logic tx, input int ch, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (tx) tx_pop <= 4'(1 << ch);
            else rx_push <= 4'(1 << ch);
        end
        @(posedge aclk);
        tx_pop <= 4'h0;
        rx_push <= 4'h0;
    endtask
endmodule

//--- test/tb_qhp_top.sv
// testbench for the quad uart host port status block
// axi4-lite master tasks; host accesses go through the command word
`timescale 1ns/1ps
module tb_qhp_top;
    import qhp_pkg::*;
    // ====================
    // signals
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_in, osc_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [3:0] rx_push, tx_pop, irq_out, rx_ready_n, tx_ready_n;
    logic [7:0] q;
    int error_cnt = 0, samples_checked = 0;
    qhp_top i_dut (.*);
    qhp_serial_model i_ser (.aclk(aclk), .osc_in(osc_in), .rx_push(rx_push), .tx_pop(tx_pop));
    always #10 aclk = ~aclk;
    // ====================
    // tasks
    task test_done;
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ready is looked at on the falling edge, so it is the value the next rising edge takes
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic v, h, a1, w1, r1;
        h = 1'b0;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (int t = 0; t < 100 && !h; t++) begin
            @(negedge aclk);
            v = wr ? s_axi_bvalid : s_axi_rvalid;
            h = v && (wr ? s_axi_bready : s_axi_rready);
            a1 = s_axi_awready;
            w1 = s_axi_wready;
            r1 = s_axi_arready;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (a1) s_axi_awvalid <= 1'b0;
            if (w1) s_axi_wvalid <= 1'b0;
            if (r1) s_axi_arvalid <= 1'b0;
            if (h) s_axi_bready <= 1'b0;
            if (h) s_axi_rready <= 1'b0;
        end
        if (!h) begin
            error_cnt++;
            test_done;
        end
    endtask
    // eight data bits, three address lines, direction bit
    function automatic logic [31:0] cmd(input logic wr, input logic [3:0] sel, input logic [2:0] ra, input logic [7:0] d);
        return {15'h0, wr, sel, 1'b0, ra, d};
    endfunction
    function automatic logic [3:0] sl(input int s, input int i);
        logic [1:0] c;
        c = 2'(i);
        return (s != 0) ? ~(4'h1 << c) : {c[1], c[0], 2'b10};
    endfunction
    task automatic hw(input logic [3:0] sel, input logic [2:0] ra, input logic [7:0] d);
        axi(1'b1, ADDR_HOST_CMD, cmd(1'b1, sel, ra, d));
    endtask
    task automatic hr(input logic [3:0] sel, input logic [2:0] ra);
        axi(1'b1, ADDR_HOST_CMD, cmd(1'b0, sel, ra, 8'h0));
        axi(1'b0, ADDR_HOST_RDATA, 32'h0);
        q = rd[7:0];
    endtask
    task automatic cs(input logic [3:0] i, input logic [3:0] r, input logic [3:0] t);
        axi(1'b0, ADDR_CHAN_STAT, 32'h0);
        chk(rd, {20'h0, i, r, t});
    endtask
    // ====================
    // scenarios
    initial begin
        int t;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        cs(4'h0, 4'hf, 4'h0);
        axi(1'b0, 8'h14, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        axi(1'b1, 8'h14, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        // both bus styles, every channel code
        for (int s = 1; s >= 0; s--) begin
            axi(1'b1, ADDR_CFG, 32'(s));
            for (int i = 0; i < 4; i++) begin
                hw(sl(s, i), OFS_DATA, 8'h5a);
                cs(4'h0, 4'hf, 4'(1 << i));
                hr(sl(s, i), OFS_LSR);
                chk({24'h0, q}, 32'h00);
                hr(sl(s, i ^ 1), OFS_LSR);
                chk({24'h0, q}, 32'h60);
                i_ser.pulse(1'b1, i, 1);
            end
        end
        axi(1'b1, ADDR_CFG, 32'h3);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        axi(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h3);
        cs(4'hf, 4'hf, 4'h0);
        axi(1'b1, ADDR_CFG, 32'h1);
        cs(4'h0, 4'hf, 4'h0);
        hw(4'h0, OFS_MCR, 8'h08);
        axi(1'b0, ADDR_HOST_CMD, 32'h0);
        chk(rd, 32'h0001_0408);
        hr(4'b1101, OFS_MCR);
        chk({24'h0, q}, 32'h08);
        cs(4'hf, 4'hf, 4'h0);
        hw(4'b1011, OFS_DATA, 8'h11);
        cs(4'b1011, 4'hf, 4'b0100);
        i_ser.pulse(1'b0, 2, 1);
        cs(4'hf, 4'b1011, 4'b0100);
        axi(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0001_0000);
        hr(4'b1011, OFS_DATA);
        i_ser.pulse(1'b1, 2, 1);
        cs(4'hf, 4'hf, 4'h0);
        // block mode on channel a, trigger 16
        hw(4'b1110, OFS_FCR, 8'h49);
        i_ser.pulse(1'b0, 0, 15);
        cs(4'hf, 4'hf, 4'h0);
        i_ser.pulse(1'b0, 0, 1);
        cs(4'hf, 4'b1110, 4'h0);
        repeat (15) hr(4'b1110, OFS_DATA);
        cs(4'hf, 4'b1110, 4'h0);
        hr(4'b1110, OFS_DATA);
        cs(4'hf, 4'hf, 4'h0);
        i_ser.pulse(1'b0, 0, 1);
        for (t = 0; t < 200 && rx_ready_n[0] !== 1'b0; t++) @(negedge aclk);
        chk({31'h0, rx_ready_n[0]}, 32'h0);
        chk(32'(t >= RX_TIMEOUT_CYC && t <= RX_TIMEOUT_CYC + 2), 32'h1);
        hr(4'b1110, OFS_DATA);
        for (int k = 1; k <= 64; k++) begin
            hw(4'b1110, OFS_DATA, 8'(k));
            @(negedge aclk);
            if (k == 16 || k == 17) chk({31'h0, irq_out[0]}, 32'(k == 16));
            if (k >= 63) chk({31'h0, tx_ready_n[0]}, 32'(k == 64));
        end
        hr(4'b1110, OFS_LSR);
        chk({24'h0, q}, 32'h00);
        i_ser.pulse(1'b1, 0, 64);
        cs(4'hf, 4'hf, 4'h0);
        // channel reset clears modem bits and held bytes, bus side keeps its setup
        i_ser.pulse(1'b0, 3, 1);
        cs(4'hf, 4'h7, 4'h0);
        axi(1'b1, ADDR_CFG, 32'h5);
        repeat (4) @(posedge aclk);
        axi(1'b1, ADDR_CFG, 32'h1);
        cs(4'h0, 4'hf, 4'h0);
        axi(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h1);
        test_done;
    end
endmodule
